/* core/pic_regs.svh */
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// control bus register offsets
`define PIC_ADDR_CONFIG     6'h01
`define PIC_ADDR_FLAGS      6'h02
`define PIC_ADDR_MASK       6'h03
`define PIC_ADDR_TXCTL      6'h04
`define PIC_ADDR_FLAG_CMP   6'h1a
`define PIC_ADDR_TX_CMP     6'h1b

// read-only registers that reject host writes
`define PIC_ADDR_RO_0       6'h08
`define PIC_ADDR_RO_1       6'h0f
`define PIC_ADDR_RO_2       6'h10
`define PIC_ADDR_RO_3       6'h13
`define PIC_ADDR_RO_4       6'h14
`define PIC_ADDR_RO_5       6'h16
`define PIC_ADDR_RO_6       6'h18
`define PIC_ADDR_RO_7       6'h19
`define PIC_ADDR_RO_8       6'h25

// interrupt_condition_flags bit positions
`define PIC_BIT_REQ_PAR     0
`define PIC_BIT_HOST_PAR    1
`define PIC_BIT_RO_REJECT   2
`define PIC_BIT_CMP_INHIBIT 3
`define PIC_BIT_LEM         4
`define PIC_BIT_RCV_A       5
`define PIC_BIT_RCV_B       6
`define PIC_BIT_SENSE       7

// transmit_state_control: request parity check enable
`define PIC_BIT_TX_PAR_EN   6

// reset values
`define PIC_FLAGS_RST       8'h10
`define PIC_MASK_RST        8'h00
`define PIC_TXCTL_RST       8'ha2
`define PIC_CMP_RST         8'h00

// flag bits that a host write can clear; the upper three follow live levels
`define PIC_FLAG_WRITABLE   8'h1f

// parity sense of host bus and request data: odd
`define PIC_PARITY_ODD      1'b1

`endif

/* core/pic_pkg.sv */
`default_nettype none

package pic_pkg;

  typedef enum logic [3:0] {
    PIC_IDLE  = 4'h1,
    PIC_WRITE = 4'h2,
    PIC_HOLD  = 4'h4,
    PIC_READ  = 4'h8
  } pic_bus_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
  } pic_req_bus_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } pic_strobe_t;

  typedef struct packed {
    pic_strobe_t    wr;
    pic_strobe_t    rd;
    pic_bus_state_t bus;
    logic [5:0]     addr;
    logic [7:0]     wdata;
    logic           wpar;
    logic [7:0]     flags;
    logic [7:0]     mask;
    logic [7:0]     flag_cmp;
    logic [7:0]     tx_ctl;
    logic [7:0]     tx_cmp;
    logic           int_n;
    logic [7:0]     rdata;
    logic           rpar;
    logic           data_oe;
    logic           ext_we;
    logic [5:0]     ext_addr;
    logic [7:0]     ext_wdata;
  } pic_core_state_t;

  typedef struct packed {
    logic err;
  } pic_par_state_t;

endpackage

`default_nettype wire

/* core/pic_req_parity.sv */
`include "pic_regs.svh"
`default_nettype none

module pic_req_parity (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire pic_pkg::pic_req_bus_t req_bus [4],
  input  wire logic [1:0]          source_sel,
  input  wire logic                enters_tx,
  input  wire logic                check_en,
  output var  logic                parity_err
);

  logic [3:0]              bad;
  pic_pkg::pic_par_state_t st;
  pic_pkg::pic_par_state_t next_st;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bus
      assign bad[i] = (^{req_bus[i].data, req_bus[i].parity}) != `PIC_PARITY_ODD;
    end
  endgenerate

  // only the bus routed into the transmitter is judged; pass-through buses are ignored
  always_comb begin
    next_st     = st;
    next_st.err = check_en && enters_tx && bad[source_sel];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign parity_err = st.err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sel_bus_err: assert property (check_en && enters_tx && bad[source_sel] |=> parity_err)
    else $error("selected request bus parity error not reported");
  a_no_tx_quiet: assert property (!(check_en && enters_tx) |=> !parity_err)
    else $error("parity error reported without checked transmitter data");

endmodule

`default_nettype wire

/* core/pic_flags.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`include "pic_regs.svh"
`default_nettype none

module pic_flags (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET,
  input  wire logic [5:0]            CB_ADDR,
  input  wire logic [7:0]            CB_DATA_I,
  input  wire logic                  CB_PAR_I,
  input  wire logic                  CB_WR_N,
  input  wire logic                  CB_RD_N,
  output logic      [7:0]            CB_DATA_O,
  output logic                       CB_PAR_O,
  output logic                       CB_DATA_OE,
  input  wire pic_pkg::pic_req_bus_t REQ_BUS [4],
  input  wire logic [1:0]            TX_SOURCE_SEL,
  input  wire logic                  TX_DATA_VALID,
  input  wire logic                  SCRUB_ACTIVE,
  input  wire logic                  LINK_ERR_ZERO,
  input  wire logic                  EXT_COND_INHIBIT,
  input  wire logic [7:0]            RCV_COND_A,
  input  wire logic [7:0]            RCV_MASK_A,
  input  wire logic [7:0]            RCV_COND_B,
  input  wire logic [7:0]            RCV_MASK_B,
  input  wire logic [2:0]            SENSE,
  output logic                       INT_N,
  output logic      [7:0]            TX_STATE_CTL,
  output logic                       EXT_WE,
  output logic      [5:0]            EXT_ADDR,
  output logic      [7:0]            EXT_WDATA
);

  pic_pkg::pic_core_state_t st;
  pic_pkg::pic_core_state_t next_st;
  logic                     req_par_err;
  logic                     wr_fall;
  logic                     rd_fall;
  logic                     wpar_bad;
  logic                     ro_hit;
  logic [7:0]               flag_keep;
  logic [7:0]               tx_keep;

  //////////////////////////////////////////////////////////////////////////////

  pic_req_parity u_req_parity (
    .clk        (CLK_SYS),
    .reset      (RESET),
    .req_bus    (REQ_BUS),
    .source_sel (TX_SOURCE_SEL),
    .enters_tx  (TX_DATA_VALID),
    .check_en   (st.tx_ctl[`PIC_BIT_TX_PAR_EN]),
    .parity_err (req_par_err)
  );

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic is_readonly(input logic [5:0] a);
    case (a)
      `PIC_ADDR_RO_0, `PIC_ADDR_RO_1, `PIC_ADDR_RO_2,
      `PIC_ADDR_RO_3, `PIC_ADDR_RO_4, `PIC_ADDR_RO_5,
      `PIC_ADDR_RO_6, `PIC_ADDR_RO_7, `PIC_ADDR_RO_8: is_readonly = 1'b1;
      default:                                        is_readonly = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] read_mux(input pic_pkg::pic_core_state_t s);
    case (s.addr)
      `PIC_ADDR_FLAGS:    read_mux = s.flags;
      `PIC_ADDR_MASK:     read_mux = s.mask;
      `PIC_ADDR_TXCTL:    read_mux = s.tx_ctl;
      `PIC_ADDR_FLAG_CMP: read_mux = s.flag_cmp;
      `PIC_ADDR_TX_CMP:   read_mux = s.tx_cmp;
      default:            read_mux = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // strobe change is accepted only once the second and third stages agree
  assign wr_fall   = st.wr.level && (st.wr.sync[1] == st.wr.sync[2]) && !st.wr.sync[2];
  assign rd_fall   = st.rd.level && (st.rd.sync[1] == st.rd.sync[2]) && !st.rd.sync[2];
  assign wpar_bad  = (^{st.wdata, st.wpar}) != `PIC_PARITY_ODD;
  assign ro_hit    = is_readonly(st.addr);
  // a bit that moved since the host loaded its compare copy must not be cleared
  assign flag_keep = (st.flags ^ st.flag_cmp) & `PIC_FLAG_WRITABLE;
  assign tx_keep   = st.tx_ctl ^ st.tx_cmp;

  always_comb begin
    next_st           = st;
    next_st.wr.sync   = {st.wr.sync[1:0], CB_WR_N};
    next_st.rd.sync   = {st.rd.sync[1:0], CB_RD_N};
    if (st.wr.sync[1] == st.wr.sync[2]) begin
      next_st.wr.level = st.wr.sync[2];
    end
    if (st.rd.sync[1] == st.rd.sync[2]) begin
      next_st.rd.level = st.rd.sync[2];
    end
    next_st.ext_we    = 1'b0;

    case (st.bus)
      pic_pkg::PIC_IDLE: begin
        if (wr_fall) begin
          // address and data are held by the host while its strobe is low
          next_st.addr  = CB_ADDR;
          next_st.wdata = CB_DATA_I;
          next_st.wpar  = CB_PAR_I;
          next_st.bus   = pic_pkg::PIC_WRITE;
        end else if (rd_fall) begin
          next_st.addr  = CB_ADDR;
          next_st.bus   = pic_pkg::PIC_READ;
        end
      end
      pic_pkg::PIC_WRITE: begin
        next_st.bus = pic_pkg::PIC_HOLD;
        // a write with bad parity is dropped whole, whatever its address
        if (wpar_bad) begin
          next_st.flags[`PIC_BIT_HOST_PAR] = 1'b1;
        end else if (ro_hit) begin
          next_st.flags[`PIC_BIT_RO_REJECT] = 1'b1;
        end else begin
          case (st.addr)
            `PIC_ADDR_CONFIG: begin
              if (SCRUB_ACTIVE) begin
                next_st.flags[`PIC_BIT_CMP_INHIBIT] = 1'b1;
              end else begin
                next_st.ext_we    = 1'b1;
                next_st.ext_addr  = st.addr;
                next_st.ext_wdata = st.wdata;
              end
            end
            `PIC_ADDR_FLAGS: begin
              // writes only clear; kept bits survive whatever is written
              next_st.flags = st.flags & (st.wdata | flag_keep | ~`PIC_FLAG_WRITABLE);
              if (|flag_keep) begin
                next_st.flags[`PIC_BIT_CMP_INHIBIT] = 1'b1;
              end
            end
            `PIC_ADDR_MASK: begin
              next_st.mask = st.wdata;
            end
            `PIC_ADDR_FLAG_CMP: begin
              next_st.flag_cmp = st.wdata;
            end
            `PIC_ADDR_TXCTL: begin
              next_st.tx_ctl = (st.tx_ctl & tx_keep) | (st.wdata & ~tx_keep);
              if (|tx_keep) begin
                next_st.flags[`PIC_BIT_CMP_INHIBIT] = 1'b1;
              end
            end
            `PIC_ADDR_TX_CMP: begin
              next_st.tx_cmp = st.wdata;
            end
            default: begin
              next_st.ext_we    = 1'b1;
              next_st.ext_addr  = st.addr;
              next_st.ext_wdata = st.wdata;
            end
          endcase
        end
      end
      pic_pkg::PIC_HOLD: begin
        // no new access until the released strobe has been accepted
        if (next_st.wr.level) begin
          next_st.bus = pic_pkg::PIC_IDLE;
        end
      end
      pic_pkg::PIC_READ: begin
        // read data follows the live flags for as long as the strobe stays low
        if (next_st.rd.level) begin
          next_st.bus = pic_pkg::PIC_IDLE;
        end
      end
      default: begin
        next_st.bus = pic_pkg::PIC_IDLE;
      end
    endcase

    // hardware events are applied after the host write, so a set beats a clear
    if (req_par_err) begin
      next_st.flags[`PIC_BIT_REQ_PAR] = 1'b1;
    end
    if (EXT_COND_INHIBIT) begin
      next_st.flags[`PIC_BIT_CMP_INHIBIT] = 1'b1;
    end
    if (LINK_ERR_ZERO) begin
      next_st.flags[`PIC_BIT_LEM] = 1'b1;
    end
    next_st.flags[`PIC_BIT_RCV_A] = |(RCV_COND_A & RCV_MASK_A);
    next_st.flags[`PIC_BIT_RCV_B] = |(RCV_COND_B & RCV_MASK_B);
    next_st.flags[`PIC_BIT_SENSE] = |SENSE;

    next_st.int_n   = ~|(next_st.flags & next_st.mask);
    next_st.data_oe = (next_st.bus == pic_pkg::PIC_READ);
    next_st.rdata   = read_mux(next_st);
    next_st.rpar    = ~^next_st.rdata;
  end

  // reset loads the flag word with the threshold bit already set
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st           <= '0;
      st.wr        <= '1;
      st.rd        <= '1;
      st.bus       <= pic_pkg::PIC_IDLE;
      st.flags     <= `PIC_FLAGS_RST;
      st.mask      <= `PIC_MASK_RST;
      st.flag_cmp  <= `PIC_CMP_RST;
      st.tx_ctl    <= `PIC_TXCTL_RST;
      st.tx_cmp    <= `PIC_CMP_RST;
      st.int_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign INT_N        = st.int_n;
  assign CB_DATA_O    = st.rdata;
  assign CB_PAR_O     = st.rpar;
  assign CB_DATA_OE   = st.data_oe;
  assign TX_STATE_CTL = st.tx_ctl;
  assign EXT_WE       = st.ext_we;
  assign EXT_ADDR     = st.ext_addr;
  assign EXT_WDATA    = st.ext_wdata;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  logic wr_ok;
  assign wr_ok = (st.bus == pic_pkg::PIC_WRITE) && !wpar_bad && !ro_hit;

  a_int_mask_gate: assert property (INT_N == !(|(st.flags & st.mask)))
    else $error("interrupt output disagrees with masked flags");
  a_req_par_set: assert property (req_par_err |=> st.flags[`PIC_BIT_REQ_PAR])
    else $error("request parity flag not set");
  a_host_par_set: assert property ((st.bus == pic_pkg::PIC_WRITE) && wpar_bad
      |=> st.flags[`PIC_BIT_HOST_PAR] && !EXT_WE && $stable(st.mask))
    else $error("host parity error not flagged or write not dropped");
  a_ro_reject: assert property ((st.bus == pic_pkg::PIC_WRITE) && !wpar_bad && ro_hit
      |=> st.flags[`PIC_BIT_RO_REJECT] && !EXT_WE)
    else $error("read-only write not rejected");
  // a kept bit that was low may be raised by an event, so only kept ones are watched
  a_cmp_keep: assert property (wr_ok && st.addr == `PIC_ADDR_FLAGS && |flag_keep
      |=> st.flags[`PIC_BIT_CMP_INHIBIT]
          && !(|($past(st.flags) & $past(flag_keep) & ~st.flags)))
    else $error("mismatched flag bits were written");
  a_inhibit_hold: assert property (st.flags[`PIC_BIT_CMP_INHIBIT]
      && !(wr_ok && st.addr == `PIC_ADDR_FLAGS) |=> st.flags[`PIC_BIT_CMP_INHIBIT])
    else $error("compare inhibit flag cleared by hardware");
  a_scrub_refuse: assert property (wr_ok && st.addr == `PIC_ADDR_CONFIG && SCRUB_ACTIVE
      |=> !EXT_WE ##1 !EXT_WE)
    else $error("configuration write passed during scrub");
  a_ext_pulse: assert property (EXT_WE |=> !EXT_WE)
    else $error("external write strobe longer than one cycle");
  // a host write may only lower flags; bit 3 and the live bits are watched elsewhere
  a_wr_clear_only: assert property (wr_ok && st.addr == `PIC_ADDR_FLAGS
      && !req_par_err && !LINK_ERR_ZERO
      |=> !(|(st.flags & ~$past(st.flags) & 8'h17)))
    else $error("flag register write raised a flag bit");
  a_read_answer: assert property (st.bus == pic_pkg::PIC_IDLE && rd_fall && !wr_fall
      |=> CB_DATA_OE)
    else $error("read strobe accepted without driving the data pins");
  a_lem_set: assert property (LINK_ERR_ZERO |=> st.flags[`PIC_BIT_LEM])
    else $error("link error threshold flag not set");
  a_rcv_a_level: assert property (##1 st.flags[`PIC_BIT_RCV_A]
      == $past(|(RCV_COND_A & RCV_MASK_A)))
    else $error("receive summary A flag wrong");
  a_rcv_b_level: assert property (##1 st.flags[`PIC_BIT_RCV_B]
      == $past(|(RCV_COND_B & RCV_MASK_B)))
    else $error("receive summary B flag wrong");
  a_sense_level: assert property (SENSE == 3'h0 |=> !st.flags[`PIC_BIT_SENSE])
    else $error("user sense flag set with all sense bits low");

  c_flag_clear: cover property (wr_ok && st.addr == `PIC_ADDR_FLAGS && !(|flag_keep));
  c_read_done:  cover property (st.bus == pic_pkg::PIC_READ ##1 st.bus == pic_pkg::PIC_IDLE);
  c_int_fire:   cover property ($fell(INT_N));
  c_inhibit:    cover property ($rose(st.flags[`PIC_BIT_CMP_INHIBIT]));
  c_scrub_block: cover property (wr_ok && st.addr == `PIC_ADDR_CONFIG && SCRUB_ACTIVE);

endmodule

`default_nettype wire

/* verif/pic_host_model.sv */
`default_nettype none

// host on the control bus: a write strobe is held for six cycles, a read strobe until the block has answered
module pic_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_oe,
  input  wire logic       rd_par,
  output var  logic [5:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wpar,
  output var  logic       wr_n,
  output var  logic       rd_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last_par;

  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wpar = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end

  // odd parity, flipped on request; released data pins show the inverse
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic bad);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wpar <= ~^d ^ bad;
    wr_n <= 1'b0;
    repeat (6) @(posedge clk);
    wr_n <= 1'b1;
    wdata <= ~d;
    wpar <= ^d ^ bad;
    repeat (6) @(posedge clk);
  endtask

  // read data is taken at the edge that first sees the output enable high
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    int n;
    d = 8'hxx;
    last_par = 1'bx;
    @(posedge clk);
    addr <= a;
    rd_n <= 1'b0;
    for (n = 0; n < 12; n++) begin
      @(posedge clk);
      if (rd_oe === 1'b1) begin
        d = rd_data;
        last_par = rd_par;
        break;
      end
    end
    rd_n <= 1'b1;
    for (n = 0; n < 12 && rd_oe !== 1'b0; n++) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* verif/tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_sys;
  logic       reset;
  logic [5:0] cb_addr;
  logic [7:0] cb_di;
  logic       cb_pi;
  logic       cb_wr_n;
  logic       cb_rd_n;
  logic [7:0] cb_do;
  logic       cb_oe;
  logic       cb_po;
  logic [1:0] tx_sel;
  logic       tx_vld;
  logic       scrub;
  logic       lem_zero;
  logic       ext_inh;
  logic [7:0] cond_a;
  logic [7:0] mask_a;
  logic [7:0] cond_b;
  logic [7:0] mask_b;
  logic [2:0] sense;
  logic       int_n;
  logic [7:0] tx_ctl;
  logic       ext_we;
  logic [5:0] ext_addr;
  logic [7:0] ext_wdata;
  logic [7:0] v;
  logic [5:0] ro [9] = '{6'h08, 6'h0f, 6'h10, 6'h13, 6'h14, 6'h16, 6'h18, 6'h19, 6'h25};
  logic [2:0] sv [6] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h2, 3'h0};
  int         n_mismatch;
  int         comparisons;
  int         n_ext;
  int         cycles;

  pic_pkg::pic_req_bus_t req_bus [4];

  pic_flags dut_u (
    .CLK_SYS(clk_sys), .RESET(reset), .CB_ADDR(cb_addr), .CB_DATA_I(cb_di),
    .CB_PAR_I(cb_pi), .CB_WR_N(cb_wr_n), .CB_RD_N(cb_rd_n), .CB_DATA_O(cb_do),
    .CB_PAR_O(cb_po), .CB_DATA_OE(cb_oe), .REQ_BUS(req_bus), .TX_SOURCE_SEL(tx_sel),
    .TX_DATA_VALID(tx_vld), .SCRUB_ACTIVE(scrub), .LINK_ERR_ZERO(lem_zero),
    .EXT_COND_INHIBIT(ext_inh), .RCV_COND_A(cond_a), .RCV_MASK_A(mask_a),
    .RCV_COND_B(cond_b), .RCV_MASK_B(mask_b), .SENSE(sense), .INT_N(int_n),
    .TX_STATE_CTL(tx_ctl), .EXT_WE(ext_we), .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata)
  );

  pic_host_model host_u (
    .clk(clk_sys), .rd_data(cb_do), .rd_oe(cb_oe), .rd_par(cb_po), .addr(cb_addr),
    .wdata(cb_di), .wpar(cb_pi), .wr_n(cb_wr_n), .rd_n(cb_rd_n)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // the run needs some 2000 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (ext_we === 1'b1) n_ext <= n_ext + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  ////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
    chk("read parity", {7'h0, host_u.last_par}, {7'h0, ~^exp});
  endtask

  // compare loaded with what was read, so bits raised meanwhile survive
  task automatic clr();
    logic [7:0] d;
    host_u.rd(6'h02, d);
    host_u.wr(6'h1a, d, 1'b0);
    host_u.wr(6'h02, 8'h00, 1'b0);
  endtask

  task automatic pulse(input int w);
    if (w == 0) lem_zero <= 1'b1;
    else ext_inh <= 1'b1;
    @(posedge clk_sys);
    lem_zero <= 1'b0;
    ext_inh <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // all buses carry 3c; only bus bad has its parity flipped
  task automatic tx_try(input int sel, input int bad, input logic vld);
    foreach (req_bus[i]) begin
      req_bus[i].data <= 8'h3c;
      req_bus[i].parity <= (i != bad);
    end
    tx_sel <= sel[1:0];
    tx_vld <= vld;
    @(posedge clk_sys);
    tx_vld <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////
  initial begin
    {scrub, lem_zero, ext_inh, tx_vld, tx_sel, sense} <= 9'h000;
    {cond_a, mask_a, cond_b, mask_b} <= 32'h0;
    foreach (req_bus[i]) req_bus[i] <= 9'h079;
    do_reset();
    rdc(6'h02, 8'h10);
    rdc(6'h03, 8'h00);
    rdc(6'h04, 8'ha2);
    chk("int_n", {7'h0, int_n}, 8'h01);
    host_u.wr(6'h03, 8'h10, 1'b0);
    chk("int_n", {7'h0, int_n}, 8'h00);
    host_u.wr(6'h03, 8'hef, 1'b0);
    chk("int_n", {7'h0, int_n}, 8'h01);
    clr();
    rdc(6'h02, 8'h00);
    pulse(0);
    rdc(6'h02, 8'h10);
    repeat (100) @(posedge clk_sys);
    rdc(6'h02, 8'h10);
    clr();
    host_u.wr(6'h03, 8'h22, 1'b1);
    rdc(6'h03, 8'hef);
    rdc(6'h02, 8'h02);
    chk("int_n", {7'h0, int_n}, 8'h00);
    foreach (ro[i]) begin
      clr();
      host_u.wr(ro[i], 8'h55, 1'b0);
      rdc(6'h02, 8'h04);
    end
    host_u.wr(6'h03, 8'hef, 1'b1);
    host_u.wr(6'h1a, 8'h02, 1'b0);
    host_u.wr(6'h02, 8'h00, 1'b0);
    rdc(6'h02, 8'h0c);
    repeat (100) @(posedge clk_sys);
    rdc(6'h02, 8'h0c);
    clr();
    host_u.wr(6'h1a, 8'h00, 1'b0);
    host_u.wr(6'h02, 8'hff, 1'b0);
    rdc(6'h02, 8'h00);
    pulse(1);
    rdc(6'h02, 8'h08);
    clr();
    scrub <= 1'b1;
    host_u.wr(6'h01, 8'h5a, 1'b0);
    chk("ext_we count", n_ext[7:0], 8'h00);
    rdc(6'h02, 8'h08);
    scrub <= 1'b0;
    clr();
    host_u.wr(6'h01, 8'h5a, 1'b0);
    chk("ext_we count", n_ext[7:0], 8'h01);
    chk("ext_addr", {2'b00, ext_addr}, 8'h01);
    chk("ext_wdata", ext_wdata, 8'h5a);
    host_u.wr(6'h1b, 8'ha2, 1'b0);
    host_u.wr(6'h04, 8'he2, 1'b0);
    chk("tx_ctl", tx_ctl, 8'he2);
    for (int s = 0; s < 4; s++) begin
      tx_try(s, s, 1'b1);
      rdc(6'h02, 8'h01);
      clr();
    end
    tx_try(0, 3, 1'b1);
    tx_try(0, 0, 1'b0);
    rdc(6'h02, 8'h00);
    host_u.wr(6'h1b, 8'he2, 1'b0);
    host_u.wr(6'h04, 8'ha2, 1'b0);
    tx_try(1, 1, 1'b1);
    rdc(6'h02, 8'h00);
    for (int k = 0; k < 2; k++) begin
      {cond_a, cond_b} <= k ? 16'h0081 : 16'h8100;
      {mask_a, mask_b} <= k ? 16'h007e : 16'h7e00;
      rdc(6'h02, 8'h00);
      {mask_a, mask_b} <= k ? 16'h0001 : 16'h0100;
      v = k ? 8'h40 : 8'h20;
      rdc(6'h02, v);
      chk("int_n", {7'h0, int_n}, 8'h00);
      clr();
      rdc(6'h02, v);
      {cond_a, cond_b} <= 16'h0;
      rdc(6'h02, 8'h00);
    end
    foreach (sv[j]) begin
      sense <= sv[j];
      rdc(6'h02, sv[j] != 3'h0 ? 8'h80 : 8'h00);
    end
    host_u.wr(6'h03, 8'hff, 1'b0);
    do_reset();
    rdc(6'h03, 8'h00);
    rdc(6'h02, 8'h10);
    chk("int_n", {7'h0, int_n}, 8'h01);
    stop_test();
  end
endmodule

`default_nettype wire
